// *** rtl/dbsf_pkg.sv ***
// Package for the doorbell and status flag block: bit positions, widths, reset values
package dbsf_pkg;
   // ==========================================================
   // Command word bit positions (main side, 18 bits: bits 18..35)
   localparam int CMD_WIDTH = 18;
   localparam int CMD_FE_DOORBELL = 22;
   localparam int CMD_RELOAD_CLEAR = 23;
   localparam int CMD_RELOAD_SET = 24;
   localparam int CMD_MAIN_DB_CLEAR = 26;
   localparam int CMD_FE_XFER_CLEAR = 29;
   localparam int CMD_MAIN_XFER_CLEAR = 30;
   localparam int CMD_CHAN_LOAD = 31;
   localparam int CMD_LEVEL_ZERO = 32;
   localparam int CMD_CHAN_MSB = 33;
   localparam int CMD_BASE = 18;
   // ==========================================================
   // Status write bit positions
   localparam int SW_MAIN_DONE_SET = 15;
   localparam int SW_MAIN_DONE_CLR = 14;
   localparam int SW_MAIN_ERR_SET = 13;
   localparam int SW_MAIN_ERR_CLR = 12;
   localparam int SW_FE_DB_SET = 11;
   localparam int SW_FE_DB_CLR = 10;
   localparam int SW_FE_PAR_CLR = 9;
   localparam int SW_MAIN_DB_SET = 8;
   localparam int SW_FE_DONE_SET = 7;
   localparam int SW_FE_DONE_CLR = 6;
   localparam int SW_BR_ENABLE = 5;
   localparam int SW_BUS_PAR_CLR = 4;
   localparam int SW_BR_DISABLE = 3;
   localparam int SW_BUS_PAR_SET = 2;
   localparam int SW_FE_ERR_SET = 1;
   localparam int SW_FE_ERR_CLR = 0;
   // ==========================================================
   // Status read bit positions
   localparam int SR_MAIN_DONE = 15;
   localparam int SR_MAIN_ERR = 13;
   localparam int SR_BUF_ZERO = 12;
   localparam int SR_FE_DB = 11;
   localparam int SR_DIAG_WORD = 10;
   // ==========================================================
   // Vector table base and step, reset values
   localparam logic [8:0] VECTOR_BASE = 9'h062; // 142 octal
   localparam logic [8:0] VECTOR_STEP = 9'h008;
   localparam logic [2:0] CHANNEL_RESET = 3'h0;
   localparam logic FLAG_RESET = 1'b0;
   // State record
   typedef struct packed {
      logic fe_db;
      logic main_db;
      logic reload;
      logic boot;
      logic fe_done;
      logic fe_err;
      logic main_done;
      logic main_err;
      logic fe_mem_par;
      logic bus_par;
      logic br_en;
      logic lvl0;
      logic [2:0] chan;
      logic [15:0] rdata;
   } dbsf_state_t;
endpackage

// *** rtl/dbsf_flags.sv ***
// Doorbell and transfer status flag logic of the two-processor interface
`timescale 1ns/1ns
`default_nettype none
module dbsf_flags
   import dbsf_pkg::*;
(
   input wire logic SYS_CLK,
   input wire logic RST_N,
   input wire logic CMD_WRITE,
   input wire logic [35:18] CMD_DATA,
   input wire logic STAT_WRITE,
   input wire logic [15:0] STAT_WDATA,
   input wire logic MAIN_COUNT_ZERO,
   input wire logic MAIN_XFER_FAULT,
   input wire logic FE_COUNT_ZERO,
   input wire logic FE_XFER_FAULT,
   input wire logic FE_MEM_PARITY,
   input wire logic BUS_PARITY,
   input wire logic BUFFER_ZERO,
   input wire logic DIAG_WORD,
   input wire logic PRIVILEGED,
   output logic [15:0] STAT_RDATA,
   output logic FE_DOORBELL_IRQ,
   output logic MAIN_DOORBELL_IRQ,
   output logic [8:0] MAIN_VECTOR,
   output logic [2:0] CHANNEL,
   output logic LEVEL_ZERO_OK,
   output logic BUS_REQUEST_ENABLE,
   output logic RELOAD_BUTTON,
   output logic BOOT_START,
   output logic FE_DONE,
   output logic FE_ERROR,
   output logic FE_MEM_PARITY_FLAG,
   output logic BUS_PARITY_FLAG
);
   // ==========================================================
   // State registers
   dbsf_state_t cur;
   dbsf_state_t next_cur;
   logic c_wr;
   logic s_wr;
   logic [15:0] sw;

   // zero bits inert
   // Command decode helper, zero bits do nothing
   function automatic logic cbit(input logic [35:18] d, input int pos);
      cbit = d[pos];
   endfunction

   // ==========================================================
   // Next-state logic, hardware sets win over software clears
   always_comb
   begin
      next_cur = cur;
      c_wr = CMD_WRITE;
      s_wr = STAT_WRITE;
      sw = STAT_WDATA;
      next_cur.boot = 1'b0;
      // clears of front-end doorbell from status only
      if (s_wr && sw[SW_FE_DB_CLR])
         next_cur.fe_db = 1'b0;
      if (c_wr && cbit(CMD_DATA, CMD_FE_DOORBELL))
         next_cur.fe_db = 1'b1;
      if (s_wr && sw[SW_FE_DB_SET])
         next_cur.fe_db = 1'b1;
      if (c_wr && cbit(CMD_DATA, CMD_RELOAD_CLEAR))
         next_cur.reload = 1'b0;
      if (c_wr && cbit(CMD_DATA, CMD_RELOAD_SET))
      begin
         next_cur.reload = 1'b1;
         next_cur.boot = 1'b1;
      end
      if (c_wr && cbit(CMD_DATA, CMD_MAIN_DB_CLEAR))
         next_cur.main_db = 1'b0;
      if (s_wr && sw[SW_MAIN_DB_SET])
         next_cur.main_db = 1'b1;
      if (c_wr && cbit(CMD_DATA, CMD_FE_XFER_CLEAR))
      begin
         next_cur.fe_done = 1'b0;
         next_cur.fe_err = 1'b0;
      end
      if (s_wr && sw[SW_FE_DONE_CLR])
         next_cur.fe_done = 1'b0;
      if (s_wr && sw[SW_FE_ERR_CLR])
         next_cur.fe_err = 1'b0;
      if (FE_XFER_FAULT || (s_wr && sw[SW_FE_ERR_SET]))
         next_cur.fe_err = 1'b1;
      if ((FE_COUNT_ZERO && !FE_XFER_FAULT) || (s_wr && sw[SW_FE_DONE_SET]))
         next_cur.fe_done = 1'b1;
      if (c_wr && cbit(CMD_DATA, CMD_MAIN_XFER_CLEAR))
      begin
         next_cur.main_done = 1'b0;
         next_cur.main_err = 1'b0;
      end
      if (s_wr && sw[SW_MAIN_DONE_CLR])
         next_cur.main_done = 1'b0;
      if (s_wr && sw[SW_MAIN_ERR_CLR])
         next_cur.main_err = 1'b0;
      if (MAIN_XFER_FAULT || FE_MEM_PARITY || (s_wr && sw[SW_MAIN_ERR_SET]))
         next_cur.main_err = 1'b1;
      // done on count zero without error
      if ((MAIN_COUNT_ZERO && !MAIN_XFER_FAULT && !FE_MEM_PARITY) || (s_wr && sw[SW_MAIN_DONE_SET]))
         next_cur.main_done = 1'b1;
      if (s_wr && sw[SW_FE_PAR_CLR])
         next_cur.fe_mem_par = 1'b0;
      if (FE_MEM_PARITY)
         next_cur.fe_mem_par = 1'b1;
      if (s_wr && sw[SW_BUS_PAR_CLR])
         next_cur.bus_par = 1'b0;
      if (BUS_PARITY || (s_wr && sw[SW_BUS_PAR_SET]))
         next_cur.bus_par = 1'b1;
      // bus request gate, pending flags untouched
      if (s_wr && sw[SW_BR_DISABLE])
         next_cur.br_en = 1'b0;
      if (s_wr && sw[SW_BR_ENABLE])
         next_cur.br_en = 1'b1;
      // channel load gated by bit 31
      if (c_wr && cbit(CMD_DATA, CMD_CHAN_LOAD))
      begin
         next_cur.lvl0 = CMD_DATA[CMD_LEVEL_ZERO];
         next_cur.chan = CMD_DATA[CMD_CHAN_MSB+2:CMD_CHAN_MSB];
      end
      // read view, bit 14 and low bits zero
      next_cur.rdata = 16'h0000;
      next_cur.rdata[SR_MAIN_DONE] = next_cur.main_done;
      next_cur.rdata[SR_MAIN_ERR] = next_cur.main_err;
      next_cur.rdata[SR_BUF_ZERO] = BUFFER_ZERO;
      next_cur.rdata[SR_DIAG_WORD] = DIAG_WORD;
      next_cur.rdata[SR_FE_DB] = next_cur.fe_db;
   end

   // ==========================================================
   // State register
   always_ff @(posedge SYS_CLK or negedge RST_N)
   begin
      if (!RST_N)
         cur <= '0;
      else
         cur <= next_cur;
   end

   // ==========================================================
   // Registered outputs
   logic [8:0] vec_q;
   logic lvl_q;
   always_ff @(posedge SYS_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         vec_q <= VECTOR_BASE;
         lvl_q <= FLAG_RESET;
      end
      else
      begin
         vec_q <= VECTOR_BASE + 9'(next_cur.chan) * VECTOR_STEP;
         lvl_q <= next_cur.lvl0 || PRIVILEGED;
      end
   end

   assign STAT_RDATA = cur.rdata;
   assign FE_DOORBELL_IRQ = cur.fe_db;
   assign MAIN_DOORBELL_IRQ = cur.main_db;
   assign MAIN_VECTOR = vec_q;
   assign CHANNEL = cur.chan;
   assign LEVEL_ZERO_OK = lvl_q;
   assign BUS_REQUEST_ENABLE = cur.br_en;
   assign RELOAD_BUTTON = cur.reload;
   assign BOOT_START = cur.boot;
   assign FE_DONE = cur.fe_done;
   assign FE_ERROR = cur.fe_err;
   assign FE_MEM_PARITY_FLAG = cur.fe_mem_par;
   assign BUS_PARITY_FLAG = cur.bus_par;
endmodule
`default_nettype wire

// *** verification/dbsf_monitor.sv ***
// Checker of the doorbell and status flag block
`timescale 1ns/1ns
`default_nettype none
module dbsf_monitor (
   input wire logic SYS_CLK,
   input wire logic RST_N,
   input wire logic CMD_WRITE,
   input wire logic [35:18] CMD_DATA,
   input wire logic STAT_WRITE,
   input wire logic [15:0] STAT_WDATA,
   input wire logic [15:0] STAT_RDATA,
   input wire logic FE_DOORBELL_IRQ,
   input wire logic [8:0] MAIN_VECTOR,
   input wire logic [2:0] CHANNEL,
   input wire logic BOOT_START
);
   // ==========================================================
   // Properties on write strobes and flags
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!RST_N);
   property p_db; CMD_WRITE && CMD_DATA[22] |=> FE_DOORBELL_IRQ; endproperty
   a_db: assert property (p_db) else $error("doorbell not set");
   property p_keep; FE_DOORBELL_IRQ && !(STAT_WRITE && STAT_WDATA[10]) |=> FE_DOORBELL_IRQ; endproperty
   a_keep: assert property (p_keep) else $error("doorbell lost");
   property p_boot; CMD_WRITE && CMD_DATA[24] |=> BOOT_START; endproperty
   a_boot: assert property (p_boot) else $error("no boot pulse");
   property p_hold; !(CMD_WRITE && CMD_DATA[31]) |=> $stable(CHANNEL); endproperty
   a_hold: assert property (p_hold) else $error("channel moved");
   property p_load; CMD_WRITE && CMD_DATA[31] |=> CHANNEL == $past(CMD_DATA[35:33]); endproperty
   a_load: assert property (p_load) else $error("channel not loaded");
   property p_vec; MAIN_VECTOR == 9'h062 + {3'h0, CHANNEL, 3'h0}; endproperty
   a_vec: assert property (p_vec) else $error("vector wrong");
   property p_rd11; STAT_RDATA[11] == FE_DOORBELL_IRQ; endproperty
   a_rd11: assert property (p_rd11) else $error("read bit 11 wrong");
   property p_zero; STAT_RDATA[14] == 1'b0 && STAT_RDATA[9:0] == 10'h000; endproperty
   a_zero: assert property (p_zero) else $error("unused read bits set");
   c_boot: cover property (CMD_WRITE && CMD_DATA[24]);
   c_load: cover property (CMD_WRITE && CMD_DATA[31]);
   c_clr: cover property (FE_DOORBELL_IRQ && STAT_WRITE && STAT_WDATA[10]);
endmodule
bind dbsf_flags dbsf_monitor u_mon (.*);
`default_nettype wire

// *** verification/dbsf_host.sv ***
// Host model driving the command word and the status write port
`timescale 1ns/1ns
`default_nettype none
module dbsf_host (
   input wire logic SYS_CLK,
   output logic CMD_WRITE,
   output logic [35:18] CMD_DATA,
   output logic STAT_WRITE,
   output logic [15:0] STAT_WDATA
);
   // Idle buses at time zero
   initial
   begin
      CMD_WRITE = 1'b0;
      CMD_DATA = 18'h00000;
      STAT_WRITE = 1'b0;
      STAT_WDATA = 16'h0000;
   end
   // One-cycle command write; released data is scrambled
   task automatic cmd(input logic [35:18] d);
      @(negedge SYS_CLK);
      CMD_WRITE = 1'b1;
      CMD_DATA = d;
      @(negedge SYS_CLK);
      CMD_WRITE = 1'b0;
      CMD_DATA = ~d;
   endtask
   // One-cycle status write; released data is scrambled
   task automatic stat(input logic [15:0] d);
      @(negedge SYS_CLK);
      STAT_WRITE = 1'b1;
      STAT_WDATA = d;
      @(negedge SYS_CLK);
      STAT_WRITE = 1'b0;
      STAT_WDATA = ~d;
   endtask
endmodule
`default_nettype wire

// *** verification/tb.sv ***
// Self-checking testbench of the doorbell and status flag block
`timescale 1ns/1ns
`default_nettype none
module tb;
   logic SYS_CLK, RST_N, cw, sw;
   logic [35:18] cd;
   logic [15:0] swd, rd;
   logic [5:0] ev;
   logic [2:0] lv, ch;
   logic [8:0] vec;
   logic [9:0] o;
   int fails, tests_run;
   // ==========================================================
   // Block, host model, clock and watchdog
   dbsf_host u_host (.SYS_CLK(SYS_CLK), .CMD_WRITE(cw), .CMD_DATA(cd), .STAT_WRITE(sw), .STAT_WDATA(swd));
   dbsf_flags u_dut (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .CMD_WRITE(cw), .CMD_DATA(cd), .STAT_WRITE(sw),
      .STAT_WDATA(swd), .MAIN_COUNT_ZERO(ev[0]), .MAIN_XFER_FAULT(ev[1]), .FE_COUNT_ZERO(ev[2]),
      .FE_XFER_FAULT(ev[3]), .FE_MEM_PARITY(ev[4]), .BUS_PARITY(ev[5]), .BUFFER_ZERO(lv[0]),
      .DIAG_WORD(lv[1]), .PRIVILEGED(lv[2]), .STAT_RDATA(rd), .FE_DOORBELL_IRQ(o[0]),
      .MAIN_DOORBELL_IRQ(o[1]), .MAIN_VECTOR(vec), .CHANNEL(ch), .LEVEL_ZERO_OK(o[2]),
      .BUS_REQUEST_ENABLE(o[3]), .RELOAD_BUTTON(o[4]), .BOOT_START(o[5]), .FE_DONE(o[6]),
      .FE_ERROR(o[7]), .FE_MEM_PARITY_FLAG(o[8]), .BUS_PARITY_FLAG(o[9]));
   initial
   begin
      SYS_CLK = 1'b0;
      forever #5 SYS_CLK = ~SYS_CLK;
   end
   initial
   begin
      #100000;
      fails++;
      end_of_test();
   end
   // Compare and count
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      tests_run++;
      if (g !== e)
      begin
         fails++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   // Reset for three cycles
   task automatic rst;
      @(negedge SYS_CLK);
      RST_N = 1'b0;
      repeat (3) @(negedge SYS_CLK);
      RST_N = 1'b1;
   endtask
   // One-cycle event pulse
   task automatic pulse(input logic [5:0] m);
      @(negedge SYS_CLK);
      ev = m;
      @(negedge SYS_CLK);
      ev = 6'h00;
   endtask
   task automatic t_door;
      rst();
      chk("vec", 16'h0062, {7'h00, vec});
      u_host.cmd(18'h00010);
      chk("rd", 16'h0800, rd);
      u_host.cmd(18'h01920);
      chk("out", 16'h0001, {6'h00, o});
      u_host.stat(16'h0400);
      chk("rd", 16'h0000, rd);
      u_host.stat(16'h0800);
      chk("out", 16'h0001, {6'h00, o});
      u_host.cmd(18'h00040);
      chk("out", 16'h0031, {6'h00, o});
      u_host.cmd(18'h00020);
      chk("out", 16'h0001, {6'h00, o});
      $display("t_door done");
   endtask
   task automatic t_chan;
      rst();
      u_host.cmd(18'h2E000);
      chk("vec", 16'h008A, {7'h00, vec});
      u_host.cmd(18'h10000);
      chk("out", 16'hA004, {ch, 3'h0, o});
      u_host.cmd(18'h12000);
      chk("vec", 16'h0072, {7'h00, vec});
      lv = 3'h4;
      repeat (2) @(negedge SYS_CLK);
      chk("out", 16'h0004, {6'h00, o});
      lv = 3'h0;
      $display("t_chan done");
   endtask
   task automatic t_flags;
      rst();
      u_host.stat(16'hA082);
      chk("rd", 16'hA000, rd);
      chk("out", 16'h00C0, {6'h00, o});
      u_host.stat(16'h5041);
      chk("rd", 16'h0000, {rd[15:10], o});
      u_host.stat(16'hA082);
      u_host.cmd(18'h01800);
      chk("rd", 16'h0000, {rd[15:10], o});
      u_host.stat(16'h0124);
      chk("out", 16'h020A, {6'h00, o});
      u_host.stat(16'h0018);
      chk("out", 16'h0002, {6'h00, o});
      u_host.cmd(18'h00100);
      chk("out", 16'h0000, {6'h00, o});
      $display("t_flags done");
   endtask
   task automatic t_hw;
      rst();
      lv = 3'h3;
      pulse(6'h03);
      chk("rd", 16'h3400, rd);
      pulse(6'h01);
      chk("rd", 16'hB400, rd);
      pulse(6'h3C);
      chk("out", 16'h0380, {6'h00, o});
      u_host.stat(16'h0200);
      chk("out", 16'h0280, {6'h00, o});
      lv = 3'h0;
      $display("t_hw done");
   endtask
   task automatic end_of_test;
      $display("fails %0d tests_run %0d", fails, tests_run);
      if (fails == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // Main sequence
   initial
   begin
      fails = 0;
      tests_run = 0;
      RST_N = 1'b0;
      ev = 6'h00;
      lv = 3'h0;
      t_door();
      t_chan();
      t_flags();
      t_hw();
      end_of_test();
   end
endmodule
`default_nettype wire
